// File: timer_zero_defs.svh
`ifndef TIMER_ZERO_DEFS_SVH
`define TIMER_ZERO_DEFS_SVH

// ======================================================================
// Register byte offsets on the bus.
`define TZ_OFF_CTRL_ZERO 8'h00
`define TZ_OFF_CTRL_ONE 8'h04
`define TZ_OFF_COUNT_LOW 8'h08
`define TZ_OFF_COUNT_HIGH 8'h0c
`define TZ_OFF_IRQ 8'h10

// ======================================================================
// Field positions and reset values.
`define TZ_BIT_IRQ_FLAG 0
`define TZ_BIT_IRQ_ENABLE 1
`define TZ_RST_CTRL 8'h00
`define TZ_RST_COUNT_LOW 8'h00
`define TZ_RST_COUNT_HIGH 8'hff
`define TZ_RST_COUNT_TOP 16'hffff
`define TZ_ZERO_BYTE 8'h00
`define TZ_ONE_BYTE 8'h01
`define TZ_ZERO_NIBBLE 4'h0
`define TZ_ONE_NIBBLE 4'h1

// ======================================================================
// Bus responses, the system clock divided by four and the prescaler counter width.
`define TZ_RESP_OKAY 2'h0
`define TZ_RESP_SLVERR 2'h2
`define TZ_QUARTER_LAST 2'h3
`define TZ_QUARTER_ONE 2'h1
`define TZ_PRE_WIDTH 15

`endif

// File: timer_zero_pkg.sv
package timer_zero_pkg;

   // Control register zero, bit 7 down to bit 0.
   typedef struct packed {
      logic countEnableBit;
      logic unusedBit;
      logic outputStatusBit;
      logic wideModeSelect;
      logic [3:0] postDividerSelect;
   } ctrl_zero_t;

   // Control register one, bit 7 down to bit 0.
   typedef struct packed {
      logic [2:0] sourceSelect;
      logic asyncInputBit;
      logic [3:0] preDividerSelect;
   } ctrl_one_t;

   // Counter clock source codes.
   typedef enum logic [2:0] {
      SRC_PIN_TRUE = 3'h0,
      SRC_PIN_INV = 3'h1,
      SRC_FOSC_QUARTER = 3'h2,
      SRC_HIGH_OSC = 3'h3,
      SRC_LOW_OSC = 3'h4,
      SRC_MID_OSC = 3'h5,
      SRC_SECOND_OSC = 3'h6,
      SRC_LOGIC_CELL = 3'h7
   } source_t;

   // Register decode result.
   typedef enum logic [2:0] {
      SEL_CTRL_ZERO = 3'h0,
      SEL_CTRL_ONE = 3'h1,
      SEL_LOW = 3'h2,
      SEL_HIGH = 3'h3,
      SEL_IRQ = 3'h4,
      SEL_NONE = 3'h5
   } reg_sel_t;

endpackage

// File: timer_zero_prescaler.sv
`timescale 1ns/1ps
`include "timer_zero_defs.svh"

module timer_zero_prescaler (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clearCount,
   input wire logic runEnable,
   input wire logic sourceLevel,
   input wire logic [3:0] preDividerSelect,
   output logic prescaledLevel
);

   logic prevLevel;
   logic [`TZ_PRE_WIDTH-1:0] preCount;
   logic [3:0] tapIndex;

   // ======================================================================
   // Ripple count of source rising edges; bit n toggles every 2^n edges.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         prevLevel <= 1'b0;
         preCount <= '0;
      end else begin
         prevLevel <= sourceLevel;
         if (clearCount) begin
            preCount <= '0;
         end else if (runEnable && sourceLevel && !prevLevel) begin
            preCount <= preCount + `TZ_PRE_WIDTH'(1);
         end
      end
   end

   // The tap one below the select makes the division by two to the select.
   assign tapIndex = preDividerSelect - `TZ_ONE_NIBBLE;

   // Select the undivided source or the counter tap as the prescaled clock.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         prescaledLevel <= 1'b0;
      end else if (preDividerSelect == `TZ_ZERO_NIBBLE) begin
         prescaledLevel <= sourceLevel;
      end else begin
         prescaledLevel <= preCount[tapIndex];
      end
   end

endmodule // timer_zero_prescaler

// File: timer_zero_counter.sv
`timescale 1ns/1ps
`include "timer_zero_defs.svh"

// Contract
// - In 8-bit mode flag when low byte equals the period value.
// - In 16-bit mode flag when the count wraps from all ones to zero.
// - Flag once every post divider value plus one events.
// - Flag with enable set requests an interrupt, also waking from sleep.
// - Output pulse goes to pin routing and to other peripherals.
// - Output status bit 5 of control zero shows output level, read-only.
// - Output pulse is high for one prescaled clock period per event.
// - Visible output toggles on each rising edge of the output pulse.
// - Count enable bit 7 runs the module; clear stops it.
// - Width select bit 4 chooses 16-bit or 8-bit with a period.
// - Post divider bits 3 to 0 divide by value plus one.
// - Source select codes 2 to 7 pick internal clocks and logic cell.
// - Source code 1 feeds the external pin inverted, code 0 true.
// - Async bit 4 bypasses the quarter clock synchroniser when set.
// - Pre divider bits 3 to 0 divide by two to their value.
// - Control fields clear on reset; bit 6 of control zero reads zero.
// - Count is reached through low and high byte registers.
// - On 8-bit match clear low byte and reload period from high byte.
// - Low byte or control writes and reset clear both scalers.
// - 16-bit low read latches true high; low write loads it.
// - Async mode keeps counting in sleep; sync mode halts.
module timer_zero_counter (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic logicCellOneOutput,
   input wire logic secondaryOscClock,
   input wire logic midFreqInternalOsc,
   input wire logic lowFreqInternalOsc,
   input wire logic highFreqInternalOsc,
   input wire logic externalClockPinInput,
   input wire logic sleepMode,
   output logic timerOutputPulse,
   output logic timerOutput,
   output logic rolloverIrqRequest
);

   timer_zero_pkg::ctrl_zero_t timerControlZero;
   timer_zero_pkg::ctrl_one_t timerControlOne;
   logic [7:0] countLowByte, countHighByte, trueHigh, periodBuf;
   logic [3:0] postCount;
   logic rolloverIrqFlag, rolloverIrqEnable;
   logic awHeld, wHeld;
   logic [31:0] awAddrReg, wDataReg;
   logic wLaneReg;
   logic [5:0] srcSync1, srcSync2;
   logic [1:0] quarterCount;
   logic quarterTick, sourceLevel, prescaledLevel, runEnable;
   logic asyncPrev, syncA, syncB, syncC, syncPend, syncTick, countTick;
   logic doWrite, wrEn, lowWrite, readLow, scalerClear, countEvent, postFire;
   timer_zero_pkg::reg_sel_t wrSel, rdSel, rdSelReg;

   // ======================================================================
   // Register decode used by both the write and the read channel.
   function automatic timer_zero_pkg::reg_sel_t regSelect(input logic [31:0] addr);
      if (addr[31:8] != 24'h000000) begin
         regSelect = timer_zero_pkg::SEL_NONE;
      end else begin
         unique case (addr[7:0])
            `TZ_OFF_CTRL_ZERO: regSelect = timer_zero_pkg::SEL_CTRL_ZERO;
            `TZ_OFF_CTRL_ONE: regSelect = timer_zero_pkg::SEL_CTRL_ONE;
            `TZ_OFF_COUNT_LOW: regSelect = timer_zero_pkg::SEL_LOW;
            `TZ_OFF_COUNT_HIGH: regSelect = timer_zero_pkg::SEL_HIGH;
            `TZ_OFF_IRQ: regSelect = timer_zero_pkg::SEL_IRQ;
            default: regSelect = timer_zero_pkg::SEL_NONE;
         endcase
      end
   endfunction

   // ======================================================================
   // Write channel: address and data are taken in either order.
   assign awready = !awHeld && !bvalid;
   assign wready = !wHeld && !bvalid;
   assign doWrite = awHeld && wHeld && !bvalid;
   assign wrSel = regSelect(awAddrReg);
   assign wrEn = doWrite && wLaneReg;
   assign lowWrite = wrEn && (wrSel == timer_zero_pkg::SEL_LOW);
   assign scalerClear = lowWrite || (wrEn && (wrSel == timer_zero_pkg::SEL_CTRL_ZERO ||
      wrSel == timer_zero_pkg::SEL_CTRL_ONE));

   // Hold address and data until both are present, then answer.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddrReg <= '0;
         wDataReg <= '0;
         wLaneReg <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `TZ_RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awHeld <= 1'b1;
            awAddrReg <= awaddr;
         end
         if (wvalid && wready) begin
            wHeld <= 1'b1;
            wDataReg <= wdata;
            wLaneReg <= wstrb[0];
         end
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            bvalid <= 1'b1;
            bresp <= (wrSel == timer_zero_pkg::SEL_NONE) ? `TZ_RESP_SLVERR : `TZ_RESP_OKAY;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ======================================================================
   // Read channel: one cycle from address to data.
   assign arready = !rvalid;
   assign rdSel = regSelect(araddr);
   assign readLow = arvalid && arready && (rdSel == timer_zero_pkg::SEL_LOW);

   // Capture read data; bit 6 of control zero is forced low.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= `TZ_RESP_OKAY;
         rdSelReg <= timer_zero_pkg::SEL_NONE;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdSelReg <= rdSel;
         rresp <= (rdSel == timer_zero_pkg::SEL_NONE) ? `TZ_RESP_SLVERR : `TZ_RESP_OKAY;
         unique case (rdSel)
            timer_zero_pkg::SEL_CTRL_ZERO: rdata <= {24'h000000, timerControlZero.countEnableBit,
               1'b0, timerOutput, timerControlZero.wideModeSelect,
               timerControlZero.postDividerSelect};
            timer_zero_pkg::SEL_CTRL_ONE: rdata <= {24'h000000, timerControlOne};
            timer_zero_pkg::SEL_LOW: rdata <= {24'h000000, countLowByte};
            timer_zero_pkg::SEL_HIGH: rdata <= {24'h000000, countHighByte};
            timer_zero_pkg::SEL_IRQ: rdata <= {30'h00000000, rolloverIrqEnable, rolloverIrqFlag};
            default: rdata <= '0;
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // ======================================================================
   // Control registers; the output status bit is never written.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         timerControlZero <= `TZ_RST_CTRL;
         timerControlOne <= `TZ_RST_CTRL;
      end else if (wrEn) begin
         if (wrSel == timer_zero_pkg::SEL_CTRL_ZERO) begin
            timerControlZero.countEnableBit <= wDataReg[7];
            timerControlZero.wideModeSelect <= wDataReg[4];
            timerControlZero.postDividerSelect <= wDataReg[3:0];
         end
         if (wrSel == timer_zero_pkg::SEL_CTRL_ONE) begin
            timerControlOne <= wDataReg[7:0];
         end
      end
   end

   // Interrupt flag and enable; a new event wins over a clear.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rolloverIrqFlag <= 1'b0;
         rolloverIrqEnable <= 1'b0;
      end else begin
         if (postFire) begin
            rolloverIrqFlag <= 1'b1;
         end else if (wrEn && wrSel == timer_zero_pkg::SEL_IRQ &&
            wDataReg[`TZ_BIT_IRQ_FLAG]) begin
            rolloverIrqFlag <= 1'b0;
         end
         if (wrEn && wrSel == timer_zero_pkg::SEL_IRQ) begin
            rolloverIrqEnable <= wDataReg[`TZ_BIT_IRQ_ENABLE];
         end
      end
   end

   // Registered request; it stands in sleep as well, so it can wake the core.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rolloverIrqRequest <= 1'b0;
      end else begin
         rolloverIrqRequest <= rolloverIrqFlag && rolloverIrqEnable;
      end
   end

   // ======================================================================
   // Clock sources: every outside level passes two flip-flops first.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         srcSync1 <= '0;
         srcSync2 <= '0;
      end else begin
         srcSync1 <= {logicCellOneOutput, secondaryOscClock, midFreqInternalOsc,
            lowFreqInternalOsc, highFreqInternalOsc, externalClockPinInput};
         srcSync2 <= srcSync1;
      end
   end

   // Free divider giving the system clock divided by four and its enable.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         quarterCount <= '0;
      end else begin
         quarterCount <= quarterCount + `TZ_QUARTER_ONE;
      end
   end
   assign quarterTick = (quarterCount == `TZ_QUARTER_LAST);

   // Source multiplexer.
   always_comb begin
      unique case (timer_zero_pkg::source_t'(timerControlOne.sourceSelect))
         timer_zero_pkg::SRC_PIN_TRUE: sourceLevel = srcSync2[0];
         timer_zero_pkg::SRC_PIN_INV: sourceLevel = !srcSync2[0];
         timer_zero_pkg::SRC_FOSC_QUARTER: sourceLevel = quarterCount[1];
         timer_zero_pkg::SRC_HIGH_OSC: sourceLevel = srcSync2[1];
         timer_zero_pkg::SRC_LOW_OSC: sourceLevel = srcSync2[2];
         timer_zero_pkg::SRC_MID_OSC: sourceLevel = srcSync2[3];
         timer_zero_pkg::SRC_SECOND_OSC: sourceLevel = srcSync2[4];
         timer_zero_pkg::SRC_LOGIC_CELL: sourceLevel = srcSync2[5];
      endcase
   end

   // Sync mode stops in sleep; async mode keeps running.
   assign runEnable = timerControlZero.countEnableBit &&
      (timerControlOne.asyncInputBit || !sleepMode);

   timer_zero_prescaler prescaler (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .clearCount(scalerClear),
      .runEnable(runEnable),
      .sourceLevel(sourceLevel),
      .preDividerSelect(timerControlOne.preDividerSelect),
      .prescaledLevel(prescaledLevel)
   );

   // ======================================================================
   // Edge paths: direct in async mode; in sync mode an edge waits for the quarter enable.
   // A source as fast as the quarter clock still counts once per quarter period.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         asyncPrev <= 1'b0;
         syncA <= 1'b0;
         syncB <= 1'b0;
         syncC <= 1'b0;
         syncPend <= 1'b0;
         syncTick <= 1'b0;
      end else begin
         asyncPrev <= prescaledLevel;
         syncA <= prescaledLevel;
         syncB <= syncA;
         syncC <= syncB;
         syncTick <= quarterTick && (syncPend || (syncB && !syncC));
         if (quarterTick) begin
            syncPend <= 1'b0;
         end else if (syncB && !syncC) begin
            syncPend <= 1'b1;
         end
      end
   end
   assign countTick = runEnable && (timerControlOne.asyncInputBit ?
      (prescaledLevel && !asyncPrev) : syncTick);

   // Match in 8-bit mode, wrap from all ones in 16-bit mode.
   assign countEvent = countTick && !lowWrite && (timerControlZero.wideModeSelect ?
      ({trueHigh, countLowByte} == `TZ_RST_COUNT_TOP) : (countLowByte == periodBuf));
   assign postFire = countEvent && (postCount == timerControlZero.postDividerSelect);

   // ======================================================================
   // Counter; a software write wins over a count in the same cycle.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         countLowByte <= `TZ_RST_COUNT_LOW;
         trueHigh <= `TZ_ZERO_BYTE;
      end else if (lowWrite) begin
         countLowByte <= wDataReg[7:0];
         if (timerControlZero.wideModeSelect) begin
            trueHigh <= countHighByte;
         end
      end else if (countTick) begin
         if (timerControlZero.wideModeSelect) begin
            {trueHigh, countLowByte} <= {trueHigh, countLowByte} + 16'h0001;
         end else if (countLowByte == periodBuf) begin
            countLowByte <= `TZ_ZERO_BYTE;
         end else begin
            countLowByte <= countLowByte + `TZ_ONE_BYTE;
         end
      end
   end

   // High holding byte: software value, or true high caught on a low read.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         countHighByte <= `TZ_RST_COUNT_HIGH;
      end else if (wrEn && wrSel == timer_zero_pkg::SEL_HIGH) begin
         countHighByte <= wDataReg[7:0];
      end else if (readLow && timerControlZero.wideModeSelect) begin
         countHighByte <= trueHigh;
      end
   end

   // Period buffer reloads from the high byte on each match.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         periodBuf <= `TZ_RST_COUNT_HIGH;
      end else if (countEvent && !timerControlZero.wideModeSelect) begin
         periodBuf <= countHighByte;
      end
   end

   // Postscaler counts events and restarts after the selected ratio.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         postCount <= `TZ_ZERO_NIBBLE;
      end else if (scalerClear) begin
         postCount <= `TZ_ZERO_NIBBLE;
      end else if (postFire) begin
         postCount <= `TZ_ZERO_NIBBLE;
      end else if (countEvent) begin
         postCount <= postCount + `TZ_ONE_NIBBLE;
      end
   end

   // ======================================================================
   // Output pulse spans one prescaled period; the pin output toggles on it.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         timerOutputPulse <= 1'b0;
         timerOutput <= 1'b0;
      end else begin
         if (postFire) begin
            timerOutputPulse <= 1'b1;
            timerOutput <= !timerOutput;
         end else if (countTick) begin
            timerOutputPulse <= 1'b0;
         end
      end
   end

   // ======================================================================
   // Assertions.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   irq_request_a: assert property ((rolloverIrqFlag && rolloverIrqEnable) |=> rolloverIrqRequest)
      else $error("Interrupt request missing for enabled flag.");
   flag_set_a: assert property (postFire |=> rolloverIrqFlag)
      else $error("Flag not set after postscaled event.");
   flag_sticky_a: assert property ((rolloverIrqFlag && !(wrEn && wrSel == timer_zero_pkg::SEL_IRQ))
      |=> rolloverIrqFlag)
      else $error("Flag cleared without software.");
   match_clear_a: assert property ((countEvent && !timerControlZero.wideModeSelect) |=>
      (countLowByte == `TZ_ZERO_BYTE && periodBuf == $past(countHighByte)))
      else $error("Match did not clear count or reload period.");
   wrap_event_a: assert property ((countTick && !lowWrite && timerControlZero.wideModeSelect &&
      {trueHigh, countLowByte} == `TZ_RST_COUNT_TOP) |-> countEvent ##1
      ({trueHigh, countLowByte} == 16'h0000))
      else $error("Wide wrap not flagged or not to zero.");
   output_toggle_a: assert property (postFire |=> (timerOutput != $past(timerOutput)) &&
      timerOutputPulse)
      else $error("Output did not toggle on event.");
   status_read_a: assert property ((arvalid && arready && rdSel == timer_zero_pkg::SEL_CTRL_ZERO)
      |=> (rdata[6] == 1'b0 && rdata[5] == $past(timerOutput)))
      else $error("Control zero read shows wrong status bits.");
   stopped_a: assert property ((!timerControlZero.countEnableBit && !lowWrite) |=>
      $stable(countLowByte))
      else $error("Disabled timer changed its count.");
   sleep_halt_a: assert property ((sleepMode && !timerControlOne.asyncInputBit && !lowWrite) |=>
      $stable(countLowByte))
      else $error("Sync mode counted during sleep.");
   post_clear_a: assert property (scalerClear |=> postCount == `TZ_ZERO_NIBBLE)
      else $error("Postscaler not cleared by write.");

   flag_set_c: cover property (postFire ##1 rolloverIrqFlag);
   wide_wrap_c: cover property (countEvent && timerControlZero.wideModeSelect);
   narrow_match_c: cover property (countEvent && !timerControlZero.wideModeSelect);
   post_ratio_c: cover property (postFire && timerControlZero.postDividerSelect != `TZ_ZERO_NIBBLE);

endmodule // timer_zero_counter

// File: timer_zero_counter_bench.sv
`timescale 1ns/1ps

// ==========================================================
// Self-checking bench for the timer block over its register bus.
module timer_zero_counter_bench;
   logic sys_clk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, extPin = 1'b0;
   logic sleepMode = 1'b0, awready, wready, bvalid, arready, rvalid;
   logic timerOutputPulse, timerOutput, rolloverIrqRequest;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic [1:0] bresp, rresp;
   int n_fail = 0, total_checks = 0;

   // Clock of 8 ns period.
   always #4 sys_clk = ~sys_clk;

   timer_zero_counter i_timer_zero_counter (.sys_clk, .nrst, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .logicCellOneOutput(1'b0),
      .secondaryOscClock(1'b0), .midFreqInternalOsc(1'b0), .lowFreqInternalOsc(1'b0),
      .highFreqInternalOsc(1'b0), .externalClockPinInput(extPin), .sleepMode,
      .timerOutputPulse, .timerOutput, .rolloverIrqRequest);

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Bus write; address and data are released each at its own handshake.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      awaddr <= {24'h0, a};
      wdata <= {24'h0, d};
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fork
         begin
            do @(negedge sys_clk); while (!awready);
            @(posedge sys_clk);
            awvalid <= 1'b0;
         end
         begin
            do @(negedge sys_clk); while (!wready);
            @(posedge sys_clk);
            wvalid <= 1'b0;
         end
      join
      while (!bvalid) @(negedge sys_clk);
      chk({30'h0, bresp}, 32'h0);
      @(posedge sys_clk);
      bready <= 1'b0;
   endtask

   // Bus read compared with expected data and response.
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      @(posedge sys_clk);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge sys_clk); while (!arready);
      @(posedge sys_clk);
      arvalid <= 1'b0;
      do @(negedge sys_clk); while (!rvalid);
      chk({30'h0, rresp}, {30'h0, er});
      chk(rdata, {24'h0, e});
      @(posedge sys_clk);
      rready <= 1'b0;
   endtask

   // Rising edges on the external clock pin, then time to settle.
   task automatic pins(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         extPin <= 1'b1;
         repeat (4) @(posedge sys_clk);
         extPin <= 1'b0;
         repeat (4) @(posedge sys_clk);
      end
      repeat (24) @(posedge sys_clk);
   endtask

   task automatic testRegs();
      rd(8'h00, 8'h00, 2'h0);
      rd(8'h04, 8'h00, 2'h0);
      rd(8'h0c, 8'hff, 2'h0);
      rd(8'h14, 8'h00, 2'h2);
      wr(8'h00, 8'hff);
      rd(8'h00, 8'h9f, 2'h0);
      wr(8'h04, 8'hab);
      rd(8'h04, 8'hab, 2'h0);
      $display("registers test done");
   endtask

   task automatic testEight();
      wr(8'h04, 8'h10);
      wr(8'h0c, 8'h03);
      wr(8'h08, 8'hff);
      wr(8'h10, 8'h03);
      wr(8'h00, 8'h80);
      pins(1);
      rd(8'h10, 8'h03, 2'h0);
      chk(rolloverIrqRequest, 1);
      chk(timerOutputPulse, 1);
      chk(timerOutput, 1);
      rd(8'h00, 8'ha0, 2'h0);
      wr(8'h10, 8'h03);
      wr(8'h08, 8'h00);
      pins(2);
      rd(8'h08, 8'h02, 2'h0);
      rd(8'h10, 8'h02, 2'h0);
      pins(2);
      rd(8'h10, 8'h03, 2'h0);
      rd(8'h08, 8'h00, 2'h0);
      chk(timerOutput, 0);
      wr(8'h10, 8'h00);
      rd(8'h10, 8'h01, 2'h0);
      chk(rolloverIrqRequest, 0);
      wr(8'h00, 8'h81);
      wr(8'h10, 8'h03);
      wr(8'h08, 8'h00);
      pins(4);
      rd(8'h10, 8'h02, 2'h0);
      chk(timerOutputPulse, 0);
      pins(4);
      rd(8'h10, 8'h03, 2'h0);
      chk(timerOutputPulse, 1);
      $display("eight-bit test done");
   endtask

   task automatic testWide();
      wr(8'h00, 8'h90);
      wr(8'h10, 8'h03);
      wr(8'h0c, 8'hff);
      wr(8'h08, 8'hfe);
      pins(1);
      rd(8'h08, 8'hff, 2'h0);
      rd(8'h0c, 8'hff, 2'h0);
      rd(8'h10, 8'h02, 2'h0);
      pins(1);
      rd(8'h10, 8'h03, 2'h0);
      rd(8'h08, 8'h00, 2'h0);
      rd(8'h0c, 8'h00, 2'h0);
      wr(8'h04, 8'h12);
      wr(8'h08, 8'h00);
      pins(1);
      rd(8'h08, 8'h00, 2'h0);
      pins(7);
      rd(8'h08, 8'h02, 2'h0);
      $display("wide and prescaler test done");
   endtask

   task automatic testSleep();
      wr(8'h04, 8'h10);
      wr(8'h08, 8'h05);
      @(posedge sys_clk);
      sleepMode <= 1'b1;
      pins(2);
      rd(8'h08, 8'h07, 2'h0);
      wr(8'h04, 8'h00);
      wr(8'h08, 8'h05);
      pins(2);
      rd(8'h08, 8'h05, 2'h0);
      @(posedge sys_clk);
      sleepMode <= 1'b0;
      pins(2);
      rd(8'h08, 8'h07, 2'h0);
      wr(8'h00, 8'h10);
      pins(2);
      rd(8'h08, 8'h07, 2'h0);
      // Quarter clock source in sync mode: 32 enabled cycles give 8 counts.
      wr(8'h04, 8'h40);
      wr(8'h08, 8'h00);
      wr(8'h00, 8'h90);
      repeat (28) @(posedge sys_clk);
      wr(8'h00, 8'h10);
      rd(8'h08, 8'h08, 2'h0);
      $display("sleep and enable test done");
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Main sequence after a reset of 12 cycles.
   initial begin
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      testRegs();
      testEight();
      testWide();
      testSleep();
      final_report();
   end

   // Watchdog that ends a hung run.
   initial begin
      repeat (30000) @(posedge sys_clk);
      n_fail++;
      final_report();
   end
endmodule // timer_zero_counter_bench
